// [logic/boot_strap_consts.svh]
`ifndef BOOT_STRAP_CONSTS_SVH
`define BOOT_STRAP_CONSTS_SVH

// strap codes
`define STRAP_CPU_LE      4'h0
`define STRAP_PCIE        4'h9
`define STRAP_MGMT_ADDR0  4'ha
`define STRAP_MGMT_ADDR31 4'hb
`define STRAP_CPU_BE      4'hc
`define STRAP_HOSTED      4'hf

// management slave addresses
`define MGMT_ADDR_LOW     5'h00
`define MGMT_ADDR_HIGH    5'h1f

// cycles after reset release before strap capture
`define STRAP_DELAY_CYC   4'h4

// reset values: cpu held, strap pins idle high
`define RST_GEN_CTRL      6'h01
`define RST_STRAP_CODE    4'hf

// general control register field positions
`define GC_CPU_HOLD       0
`define GC_BIG_ENDIAN     1
`define GC_BOOT_MAP       2
`define GC_SPORT_OWNER    3
`define GC_MGMT_ENABLE    4
`define GC_PCIE_ENABLE    5
`define GC_WIDTH          6

// controller register offsets
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_CMD           12'h008
`define REG_RDATA         12'h00c

// controller command codes
`define CMD_WRITE         2'h1
`define CMD_READ          2'h2

`endif

// [logic/boot_strap_pkg.sv]
package boot_strap_pkg;
  typedef enum logic [3:0]
  {
    LD_WAIT    = 4'h1,
    LD_CAPTURE = 4'h2,
    LD_RUN     = 4'h4,
    LD_IDLE    = 4'h8
  } loader_state_e;

  typedef enum logic [2:0]
  {
    HS_IDLE = 3'h1,
    HS_REQ  = 3'h2,
    HS_DONE = 3'h4
  } host_state_e;

  typedef logic [5:0] gen_ctrl_t;
endpackage

// [logic/boot_cfg_if.sv]
`timescale 1ns/1ps
// register access path between host and device, plus strap pins
interface boot_cfg_if;
  logic [3:0] strap;
  logic       req;
  logic       we;
  logic [5:0] wdata;
  logic       ack;
  logic [5:0] rdata;

  modport device
  (
    input  strap,
    input  req,
    input  we,
    input  wdata,
    output ack,
    output rdata
  );

  modport host
  (
    output strap,
    output req,
    output we,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface

// [logic/cpu_boot_strap_config.sv]
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "boot_strap_consts.svh"
module cpu_boot_strap_config
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  boot_cfg_if.device      cfg,
  input  wire logic       debug_select_n,
  input  wire logic       jtag_tck,
  input  wire logic       jtag_tms,
  input  wire logic       jtag_tdi,
  output logic            jtag_tdo,
  input  wire logic       dbg_tdo,
  input  wire logic       bscan_tdo,
  output logic            dbg_tck,
  output logic            dbg_tms,
  output logic            dbg_tdi,
  output logic            bscan_tck,
  output logic            bscan_tms,
  output logic            bscan_tdi,
  input  wire logic       cpu_image_ready,
  input  wire logic       pcie_bar_valid,
  input  wire logic [2:0] pcie_bar,
  output logic            pcie_to_regs,
  output logic            pcie_to_dram,
  output logic            cpu_run,
  output logic            cpu_big_endian,
  output logic            boot_map_active,
  output logic            low_region_is_flash,
  output logic            serial_port_owner,
  output logic            serial_slave_enable,
  output logic            mgmt_slave_enable,
  output logic [4:0]      mgmt_address,
  output logic            pcie_enable,
  output logic [3:0]      strap_code,
  output logic            strap_captured
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    boot_strap_pkg::loader_state_e st;
    logic [3:0]                    delay;
    logic [3:0]                    code;
    boot_strap_pkg::gen_ctrl_t     ctrl;
    logic                          map_live;
    logic                          ack;
    logic [5:0]                    rdata;
  } dev_state_s;

  dev_state_s r;
  dev_state_s next_r;

  // ----------------------------------------------------------------
  // strap decode
  // ----------------------------------------------------------------
  function automatic boot_strap_pkg::gen_ctrl_t strap_reset_value(input logic [3:0] code);
    boot_strap_pkg::gen_ctrl_t v;
    v = '0;
    // only the two flash boot codes release the cpu
    v[`GC_CPU_HOLD] = 1'b1;
    unique case (code)
      `STRAP_CPU_LE:
      begin
        v[`GC_CPU_HOLD]    = 1'b0;
        v[`GC_BOOT_MAP]    = 1'b1;
        v[`GC_SPORT_OWNER] = 1'b1;
      end
      `STRAP_PCIE:        v[`GC_PCIE_ENABLE] = 1'b1;
      `STRAP_MGMT_ADDR0:  v[`GC_MGMT_ENABLE] = 1'b1;
      `STRAP_MGMT_ADDR31: v[`GC_MGMT_ENABLE] = 1'b1;
      `STRAP_CPU_BE:
      begin
        v[`GC_CPU_HOLD]    = 1'b0;
        v[`GC_BIG_ENDIAN]  = 1'b1;
        v[`GC_BOOT_MAP]    = 1'b1;
        v[`GC_SPORT_OWNER] = 1'b1;
      end
      default:            v[`GC_CPU_HOLD] = 1'b1;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r     = r;
    next_r.ack = 1'b0;
    unique case (r.st)
      boot_strap_pkg::LD_WAIT:
      begin
        // give strap pins time to settle after reset
        next_r.delay = r.delay + 4'h1;
        if (r.delay == `STRAP_DELAY_CYC)
          next_r.st = boot_strap_pkg::LD_CAPTURE;
      end
      boot_strap_pkg::LD_CAPTURE:
      begin
        next_r.code     = cfg.strap;
        next_r.ctrl     = strap_reset_value(cfg.strap);
        next_r.map_live = 1'b1;
        next_r.st       = boot_strap_pkg::LD_RUN;
      end
      boot_strap_pkg::LD_RUN,
      boot_strap_pkg::LD_IDLE:
      begin
        next_r.st = boot_strap_pkg::LD_RUN;
        // code is never reloaded here
        if (cfg.req && !r.ack)
        begin
          next_r.ack = 1'b1;
          if (cfg.we)
            next_r.ctrl = cfg.wdata;
          else
          begin
            next_r.rdata    = r.ctrl;
            next_r.map_live = r.ctrl[`GC_BOOT_MAP];
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r.st       <= boot_strap_pkg::LD_WAIT;
      r.delay    <= 4'h0;
      r.code     <= `RST_STRAP_CODE;
      r.ctrl     <= `RST_GEN_CTRL;
      r.map_live <= 1'b1;
      r.ack      <= 1'b0;
      r.rdata    <= 6'h00;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cfg.ack   = r.ack;
  assign cfg.rdata = r.rdata;

  // ----------------------------------------------------------------
  // startup and boot status
  // ----------------------------------------------------------------
  assign strap_captured      = (r.st == boot_strap_pkg::LD_RUN);
  assign strap_code          = r.code;
  // released cpu without serial port ownership waits for host image before start; held cpu never runs
  assign cpu_run             = strap_captured && !r.ctrl[`GC_CPU_HOLD]
                               && (r.ctrl[`GC_SPORT_OWNER] || cpu_image_ready);
  assign cpu_big_endian      = r.ctrl[`GC_BIG_ENDIAN];
  assign boot_map_active     = r.map_live;
  assign low_region_is_flash = r.map_live;
  assign serial_port_owner   = r.ctrl[`GC_SPORT_OWNER];
  // serial slave and boot ownership exclude each other
  assign serial_slave_enable = strap_captured && !r.ctrl[`GC_SPORT_OWNER];
  assign mgmt_slave_enable   = r.ctrl[`GC_MGMT_ENABLE];
  // address follows the held strap code, not the live pins
  assign mgmt_address        = (r.code == `STRAP_MGMT_ADDR31) ? `MGMT_ADDR_HIGH
                                                              : `MGMT_ADDR_LOW;
  assign pcie_enable         = r.ctrl[`GC_PCIE_ENABLE];
  // inbound window steering
  assign pcie_to_regs        = pcie_bar_valid && (pcie_bar == 3'h0);
  assign pcie_to_dram        = pcie_bar_valid && (pcie_bar == 3'h2);

  // ----------------------------------------------------------------
  // shared jtag steering
  // ----------------------------------------------------------------
  assign dbg_tck   = !debug_select_n ? jtag_tck : 1'b0;
  assign dbg_tms   = !debug_select_n ? jtag_tms : 1'b1;
  assign dbg_tdi   = !debug_select_n ? jtag_tdi : 1'b1;
  assign bscan_tck = debug_select_n ? jtag_tck : 1'b0;
  assign bscan_tms = debug_select_n ? jtag_tms : 1'b1;
  assign bscan_tdi = debug_select_n ? jtag_tdi : 1'b1;
  // return data from the selected controller only
  assign jtag_tdo  = debug_select_n ? bscan_tdo : dbg_tdo;

endmodule

// [logic/boot_host_ctrl.sv]
`timescale 1ns/1ps
`include "boot_strap_consts.svh"
// external host end: apb registers drive strap pins and register access
module boot_host_ctrl
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  boot_cfg_if.host         cfg,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  typedef struct packed
  {
    boot_strap_pkg::host_state_e st;
    logic [3:0]                  strap;
    logic [5:0]                  wdata;
    logic                        we;
    logic [5:0]                  rdata;
    logic                        done;
    logic [31:0]                 prdata;
  } host_state_s;

  host_state_s r;
  host_state_s next_r;
  logic        access;

  assign access = psel && penable;

  // ----------------------------------------------------------------
  // apb slave and access sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    unique case (r.st)
      boot_strap_pkg::HS_IDLE:
        if (access && pwrite && paddr == `REG_CMD && pwdata[1:0] != 2'h0)
        begin
          next_r.st   = boot_strap_pkg::HS_REQ;
          next_r.we   = (pwdata[1:0] == `CMD_WRITE);
          next_r.done = 1'b0;
        end
      boot_strap_pkg::HS_REQ:
        if (cfg.ack)
        begin
          next_r.rdata = cfg.rdata;
          next_r.st    = boot_strap_pkg::HS_DONE;
        end
      boot_strap_pkg::HS_DONE:
      begin
        next_r.done = 1'b1;
        next_r.st   = boot_strap_pkg::HS_IDLE;
      end
    endcase
    if (access && pwrite && paddr == `REG_CTRL)
    begin
      next_r.strap = pwdata[3:0];
      next_r.wdata = pwdata[13:8];
    end
    next_r.prdata = 32'h0;
    if (psel && !penable && !pwrite)
      unique case (paddr)
        `REG_CTRL:   next_r.prdata = {18'h0, r.wdata, 4'h0, r.strap};
        `REG_STATUS: next_r.prdata = {30'h0, r.done, r.st != boot_strap_pkg::HS_IDLE};
        `REG_RDATA:  next_r.prdata = {26'h0, r.rdata};
        default:     next_r.prdata = 32'h0;
      endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r.st     <= boot_strap_pkg::HS_IDLE;
      r.strap  <= `RST_STRAP_CODE;
      r.wdata  <= `RST_GEN_CTRL;
      r.we     <= 1'b0;
      r.rdata  <= 6'h00;
      r.done   <= 1'b0;
      r.prdata <= 32'h0;
    end
    else
      r <= next_r;
  end

  assign prdata    = r.prdata;
  assign pready    = 1'b1;
  assign pslverr   = access && !(paddr == `REG_CTRL || paddr == `REG_STATUS
                     || paddr == `REG_CMD || paddr == `REG_RDATA);
  assign cfg.strap = r.strap;
  assign cfg.req   = (r.st == boot_strap_pkg::HS_REQ);
  assign cfg.we    = r.we;
  assign cfg.wdata = r.wdata;

endmodule

// [tb/boot_cfg_props.sv]
`timescale 1ns/1ps
module boot_cfg_props
(
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [3:0] strap,
  input wire logic       req,
  input wire logic       ack,
  input wire logic       strap_captured,
  input wire logic [3:0] strap_code,
  input wire logic       serial_port_owner,
  input wire logic       serial_slave_enable,
  input wire logic       mgmt_slave_enable,
  input wire logic [4:0] mgmt_address
);
  logic [3:0] rel_cnt;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // cycles since reset release, saturating
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rel_cnt <= 4'h0;
    else if (rel_cnt != 4'hf)
      rel_cnt <= rel_cnt + 4'h1;
  end

  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; ack |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
  property p_ack_time; $rose(req) && strap_captured |=> ack; endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack late");
  property p_capture_wait; $rose(strap_captured) |-> rel_cnt >= 4'h4; endproperty
  a_capture_wait: assert property (p_capture_wait) else $error("capture early");
  property p_strap_take; $rose(strap_captured) |-> strap_code == $past(strap); endproperty
  a_strap_take: assert property (p_strap_take) else $error("wrong strap taken");
  property p_strap_hold; strap_captured |=> $stable(strap_code) && strap_captured; endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap code moved");
  property p_slave_owner;
    strap_captured |-> serial_slave_enable == !serial_port_owner;
  endproperty
  a_slave_owner: assert property (p_slave_owner) else $error("slave vs owner");
  property p_mgmt_low;
    strap_captured && strap_code == 4'ha && mgmt_slave_enable |-> mgmt_address == 5'h00;
  endproperty
  a_mgmt_low: assert property (p_mgmt_low) else $error("mgmt address not 0");
  property p_mgmt_high;
    strap_captured && strap_code == 4'hb && mgmt_slave_enable |-> mgmt_address == 5'h1f;
  endproperty
  a_mgmt_high: assert property (p_mgmt_high) else $error("mgmt address not 31");

  c_ack: cover property (ack);
  c_capture: cover property ($rose(strap_captured));
  c_mgmt: cover property (mgmt_slave_enable && strap_code == 4'hb);
endmodule

// [tb/tb_cpu_boot_strap_config.sv]
`timescale 1ns/1ps
`include "boot_strap_consts.svh"
module tb_cpu_boot_strap_config;
  localparam logic [3:0] CODES [6] = '{4'h0, 4'h9, 4'ha, 4'hb, 4'hc, 4'hf};
  localparam logic [4:0] EXP_V [6] = '{5'h10, 5'h05, 5'h06, 5'h06, 5'h18, 5'h04};
  localparam logic [4:0] MSK [6]   = '{5'h1c, 5'h15, 5'h16, 5'h16, 5'h1c, 5'h14};
  logic        core_clk = 0;
  logic        host_rstn = 0;
  logic        dev_rstn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, err;
  logic        debug_select_n = 0, cpu_image_ready = 0, pcie_bar_valid = 0;
  logic [2:0]  pcie_bar = '0;
  logic        jtag_tck = 1, jtag_tms = 0, jtag_tdi = 1, dbg_tdo = 1, bscan_tdo = 0;
  logic        jtag_tdo, dbg_tck, dbg_tms, dbg_tdi, bscan_tck, bscan_tms, bscan_tdi;
  logic        pcie_to_regs, pcie_to_dram, cpu_run, cpu_big_endian, low_region_is_flash;
  logic        serial_port_owner, serial_slave_enable, mgmt_slave_enable, pcie_enable;
  logic        strap_captured, boot_map_active;
  logic [4:0]  mgmt_address;
  logic [3:0]  strap_code;
  int          failures = 0;
  int          tests_run = 0;
  int          cyc = 0;

  boot_cfg_if cfg ();
  cpu_boot_strap_config u_cpu_boot_strap_config
  (
    .core_clk, .rstn(dev_rstn), .cfg(cfg.device), .debug_select_n, .jtag_tck, .jtag_tms,
    .jtag_tdi, .jtag_tdo, .dbg_tdo, .bscan_tdo, .dbg_tck, .dbg_tms, .dbg_tdi, .bscan_tck,
    .bscan_tms, .bscan_tdi, .cpu_image_ready, .pcie_bar_valid, .pcie_bar, .pcie_to_regs,
    .pcie_to_dram, .cpu_run, .cpu_big_endian, .boot_map_active, .low_region_is_flash,
    .serial_port_owner, .serial_slave_enable, .mgmt_slave_enable, .mgmt_address,
    .pcie_enable, .strap_code, .strap_captured
  );
  boot_host_ctrl u_boot_host_ctrl
  (
    .core_clk, .rstn(host_rstn), .cfg(cfg.host), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr
  );
  boot_cfg_props u_boot_cfg_props
  (
    .core_clk, .rstn(dev_rstn), .strap(cfg.strap), .req(cfg.req), .ack(cfg.ack),
    .strap_captured, .strap_code, .serial_port_owner, .serial_slave_enable,
    .mgmt_slave_enable, .mgmt_address
  );

  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------
  // result, check and access tasks
  // ----------------------------------------
  task conclude;
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // device register op, strap pins kept at f
  task dop(input logic [1:0] c, input logic [5:0] d);
    apb(1, `REG_CTRL, {18'h0, d, 8'h0f});
    apb(1, `REG_CMD, {30'h0, c});
    do apb(0, `REG_STATUS, 32'h0); while (rd[1:0] !== 2'b10);
    if (c == `CMD_READ)
      apb(0, `REG_RDATA, 32'h0);
  endtask

  task boot(input logic [3:0] s);
    apb(1, `REG_CTRL, {28'h0, s});
    dev_rstn <= 0;
    repeat (2) @(posedge core_clk);
    dev_rstn <= 1;
    do @(posedge core_clk); while (strap_captured !== 1'b1);
    @(posedge core_clk);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge core_clk);
    host_rstn <= 1;
    dev_rstn <= 1;
    foreach (CODES[i])
    begin
      boot(CODES[i]);
      chk("strap_code", CODES[i], strap_code);
      chk("startup", EXP_V[i], MSK[i] & {cpu_run, cpu_big_endian, serial_slave_enable,
          mgmt_slave_enable, pcie_enable});
      if (CODES[i][3:1] == 3'h5)
        chk("mgmt_address", {5{CODES[i][0]}}, mgmt_address);
    end
    apb(1, `REG_CTRL, 32'h0);
    repeat (4) @(posedge core_clk);
    chk("strap_hold", 4'hf, strap_code);
    dop(`CMD_WRITE, 6'h0e);
    chk("flash_boot", 3'h6, {cpu_run, cpu_big_endian, serial_slave_enable});
    chk("owner", 1'b1, serial_port_owner);
    dop(`CMD_READ, 6'h0);
    chk("readback", 6'h0e, rd[5:0]);
    chk("low_region", 1'b1, low_region_is_flash);
    chk("boot_map", 1'b1, boot_map_active);
    dop(`CMD_WRITE, 6'h10);
    chk("image_wait", 1'b0, cpu_run);
    chk("owner", 1'b0, serial_port_owner);
    cpu_image_ready <= 1;
    dop(`CMD_WRITE, 6'h10);
    chk("dram_boot", 4'hf, {cpu_run, serial_slave_enable, mgmt_slave_enable,
        low_region_is_flash});
    dop(`CMD_READ, 6'h0);
    chk("readback", 6'h10, rd[5:0]);
    chk("low_region", 1'b0, low_region_is_flash);
    chk("boot_map", 1'b0, boot_map_active);
    apb(0, 12'h010, 32'h0);
    chk("pslverr", 1'b1, err);
    for (int s = 0; s < 2; s++)
    begin
      debug_select_n <= s[0];
      @(posedge core_clk);
      chk("jtag", s ? 4'ha : 4'hb, {s ? {bscan_tck, bscan_tms, bscan_tdi}
          : {dbg_tck, dbg_tms, dbg_tdi}, jtag_tdo});
    end
    for (int b = 0; b < 3; b += 2)
    begin
      pcie_bar_valid <= 1;
      pcie_bar <= b[2:0];
      @(posedge core_clk);
      chk("pcie_bar", b ? 2'h1 : 2'h2, {pcie_to_regs, pcie_to_dram});
    end
    conclude();
  end
endmodule
